//--- rtl/sfc_defs.vh
// Purpose: Shared constants for the synthesizer and field command block
// Assumes: 32-bit register port, word addresses as byte offsets
// Notes: Definitions only
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH
// Register offsets
`define SFC_ADDR_SYNTH 8'h00
`define SFC_ADDR_SYNTH_STORED 8'h04
`define SFC_ADDR_CTRL 8'h08
`define SFC_ADDR_REVERSAL 8'h0C
`define SFC_ADDR_OFFSET 8'h10
`define SFC_ADDR_OFFSET_STORED 8'h14
`define SFC_ADDR_DAC 8'h18
`define SFC_ADDR_FREQ 8'h1C
`define SFC_ADDR_STATUS 8'h20
// Synthesizer word field positions
`define SFC_R_LSB 0
`define SFC_R_MSB 12
`define SFC_N_LSB 13
`define SFC_N_MSB 24
`define SFC_A_LSB 25
`define SFC_A_MSB 30
// Control register bits (write one to act)
`define SFC_CTRL_SYNTH_SAVE 0
`define SFC_CTRL_OFFSET_SAVE 1
`define SFC_CTRL_RESTART 2
// Status register bits
`define SFC_STAT_REJECT 0
`define SFC_STAT_ANALOG_OFF 1
`define SFC_STAT_POLARITY 2
// Argument limits
`define SFC_R_MIN 13'h05DC
`define SFC_R_MAX 13'h1FFF
`define SFC_N_MIN 12'h320
`define SFC_N_MAX 12'hFFF
`define SFC_A_MAX 6'h3F
`define SFC_OFFSET_MIN 12'h8FC
`define SFC_OFFSET_MAX 12'hE10
`define SFC_FREQ_LIMIT 12'h7D0
`define SFC_DAC_MIN 12'h3E8
`define SFC_DAC_MAX 12'hFFF
// Reset values
`define SFC_R_RESET 13'h0A32
`define SFC_N_RESET 12'h5BA
`define SFC_A_RESET 6'h3F
`define SFC_OFFSET_RESET 12'hBB8
`define SFC_SLOPE_NOM 1450
// Timing: half period of 5 Hz reversal
`define SFC_CLK_HZ 250000000
`define SFC_REVERSAL_HZ 5
`define SFC_HALF_CYCLES (`SFC_CLK_HZ / (2 * `SFC_REVERSAL_HZ))
`endif

//--- rtl/sfc_isqrt.v
// Purpose: Iterative integer square root, one result bit per clock
// Assumes: Operand sampled on start; it may change while busy
// Notes: Result is the floor of the root
`timescale 1ns/10ps
module sfc_isqrt #(
  parameter IN_W = 26,
  parameter OUT_W = 13
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [IN_W-1:0] operand,
  output reg busy,
  output reg done,
  output reg [OUT_W-1:0] root
);
  reg [IN_W-1:0] rem_val;
  reg [OUT_W-1:0] trial;
  reg [4:0] step;
  wire [OUT_W-1:0] cand = trial | (1'b1 << step);
  wire [2*OUT_W-1:0] cand_sq = cand * cand;

  // Greedy bit setting from the top: cheap, fixed latency of OUT_W cycles
  always @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      trial <= {OUT_W{1'b0}};
      root <= {OUT_W{1'b0}};
      rem_val <= {IN_W{1'b0}};
      step <= 5'h00;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          rem_val <= operand;
          trial <= {OUT_W{1'b0}};
          step <= OUT_W[4:0] - 5'h01;
        end
      end else begin
        if (cand_sq <= {{(2*OUT_W-IN_W){1'b0}}, rem_val}) begin
          trial <= cand;
        end
        if (step == 5'h00) begin
          busy <= 1'b0;
          done <= 1'b1;
          root <= (cand_sq <= {{(2*OUT_W-IN_W){1'b0}}, rem_val}) ? cand : trial;
        end else begin
          step <= step - 5'h01;
        end
      end
    end
  end
endmodule // sfc_isqrt

//--- rtl/sfc_control.v
// Purpose: Register-driven synthesizer divider and field coil control
// Assumes: One clock; analog calibration value arrives already on clk
// Notes: Nonvolatile copies are held in flops and survive restart only
//
// How it works
// - Set command takes R 1500..8191, N 800..4095, A 0..63 and applies them.
// - Synthesizer ratio is 19*(64*N+A)/R; outputs carry R, N, A.
// - Synthesizer query returns R, N, A in use, in that order.
// - Synthesizer save copies values in use into the stored copy.
// - Stored synthesizer query returns the stored copy, not live values.
// - Field DAC stays within 1000..4095, nominal midpoint 3000.
// - Enabled reversal flips coil current at 5 Hz; full-period mark for averaging.
// - Reversal is enabled at power-on and every restart.
// - Reversal command 1 enables, 0 disables.
// - Reversal query returns 1 when enabled, else 0.
// - Field offset set accepted only within 2300..3600.
// - Field offset query returns offset in use.
// - Offset save stores current offset; stored offset loads at reset and restart.
// - Stored offset query returns the stored value.
// - Direct frequency set disables analog input, range plus or minus 2000.
// - Field control linearised so frequency follows the requested offset.
// - DAC code is sqrt(freq*slope + offset squared), slope nominal 1450.
`timescale 1ns/10ps
`include "sfc_defs.vh"
module sfc_control #(
  parameter integer HALF_CYCLES = `SFC_HALF_CYCLES,
  parameter integer SLOPE = `SFC_SLOPE_NOM
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire [11:0] cal_offset,
  output reg [12:0] synth_r,
  output reg [11:0] synth_n,
  output reg [5:0] synth_a,
  output reg synth_load,
  output reg [11:0] field_dac,
  output reg coil_polarity,
  output reg reversal_period_mark
);
  // Root sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_LOAD = 2'b10;

  // Nonvolatile copies, live settings and flags
  reg [12:0] stored_r;
  reg [11:0] stored_n;
  reg [5:0] stored_a;
  reg [11:0] field_offset;
  reg [11:0] stored_offset;
  reg reversal_en;
  reg analog_off;
  reg [11:0] direct_freq;
  reg reject;
  reg restart_pend;
  reg [31:0] half_count;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] next_rdata;

  // Argument fields and write decodes
  wire [12:0] arg_r = wdata[`SFC_R_MSB:`SFC_R_LSB];
  wire [11:0] arg_n = wdata[`SFC_N_MSB:`SFC_N_LSB];
  wire [5:0] arg_a = wdata[`SFC_A_MSB:`SFC_A_LSB];
  wire [11:0] arg_12 = wdata[11:0];
  wire wr_synth = wr && (addr == `SFC_ADDR_SYNTH);
  wire wr_ctrl = wr && (addr == `SFC_ADDR_CTRL);
  wire wr_rev = wr && (addr == `SFC_ADDR_REVERSAL);
  wire wr_off = wr && (addr == `SFC_ADDR_OFFSET);
  wire wr_freq = wr && (addr == `SFC_ADDR_FREQ);
  wire restart_req = wr_ctrl && wdata[`SFC_CTRL_RESTART];

  // Unsigned window check, shared by the synthesizer and field offset set commands
  function in_range;
    input [12:0] v;
    input [12:0] lo;
    input [12:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  // Signed plus/minus limit on a 12-bit two's complement value
  function freq_ok;
    input [11:0] v;
    begin
      if (v[11])
        freq_ok = ((~v) + 12'h001) <= `SFC_FREQ_LIMIT;
      else
        freq_ok = v <= `SFC_FREQ_LIMIT;
    end
  endfunction

  wire synth_ok = in_range(arg_r, `SFC_R_MIN, `SFC_R_MAX) &&
                  in_range({1'b0, arg_n}, {1'b0, `SFC_N_MIN}, {1'b0, `SFC_N_MAX}) &&
                  (arg_a <= `SFC_A_MAX) && (wdata[31] == 1'b0);
  wire off_ok = in_range({1'b0, arg_12}, {1'b0, `SFC_OFFSET_MIN}, {1'b0, `SFC_OFFSET_MAX}) &&
                (wdata[31:12] == 20'h00000);
  wire rev_ok = (wdata[31:1] == 31'h00000000);
  // Upper bits must copy bit 11, else a large negative word would pass as small positive
  wire freq_arg_ok = freq_ok(arg_12) &&
                     (wdata[31:11] == 21'h000000 || wdata[31:11] == 21'h1FFFFF);
  wire bad_write = (wr_synth && !synth_ok) || (wr_off && !off_ok) ||
                   (wr_rev && !rev_ok) || (wr_freq && !freq_arg_ok);
  wire status_read = rd && (addr == `SFC_ADDR_STATUS);

  // Synthesizer dividers: live set, save, restart reload
  always @(posedge clk) begin
    if (rst) begin
      synth_r <= `SFC_R_RESET;
      synth_n <= `SFC_N_RESET;
      synth_a <= `SFC_A_RESET;
      stored_r <= `SFC_R_RESET;
      stored_n <= `SFC_N_RESET;
      stored_a <= `SFC_A_RESET;
      synth_load <= 1'b1;
    end else begin
      synth_load <= 1'b0;
      if (restart_pend) begin
        synth_r <= stored_r;
        synth_n <= stored_n;
        synth_a <= stored_a;
        synth_load <= 1'b1;
      end else if (wr_synth && synth_ok) begin
        synth_r <= arg_r;
        synth_n <= arg_n;
        synth_a <= arg_a;
        synth_load <= 1'b1;
      end
      if (wr_ctrl && wdata[`SFC_CTRL_SYNTH_SAVE]) begin
        stored_r <= synth_r;
        stored_n <= synth_n;
        stored_a <= synth_a;
      end
    end
  end

  // Field offset, reversal enable and frequency source
  always @(posedge clk) begin
    if (rst) begin
      field_offset <= `SFC_OFFSET_RESET;
      stored_offset <= `SFC_OFFSET_RESET;
      reversal_en <= 1'b1;
      analog_off <= 1'b0;
      direct_freq <= 12'h000;
      restart_pend <= 1'b0;
    end else begin
      // Restart acts one cycle later so a same-word save lands first
      restart_pend <= restart_req;
      if (restart_pend) begin
        field_offset <= stored_offset;
        reversal_en <= 1'b1;
        analog_off <= 1'b0;
        direct_freq <= 12'h000;
      end else begin
        if (wr_off && off_ok)
          field_offset <= arg_12;
        if (wr_rev && rev_ok)
          reversal_en <= wdata[0];
        if (wr_freq && freq_arg_ok) begin
          direct_freq <= arg_12;
          analog_off <= 1'b1;
        end
      end
      if (wr_ctrl && wdata[`SFC_CTRL_OFFSET_SAVE])
        stored_offset <= field_offset;
    end
  end

  // Reject flag: set beats the clear-on-read of the status word
  always @(posedge clk) begin
    if (rst)
      reject <= 1'b0;
    else if (bad_write)
      reject <= 1'b1;
    else if (status_read)
      reject <= 1'b0;
  end

  // Coil reversal timer; mark pulses once per whole switching period
  // Disabling parks the phase at zero so a re-enable starts a fresh half period
  always @(posedge clk) begin
    if (rst) begin
      half_count <= 32'h00000000;
      coil_polarity <= 1'b0;
      reversal_period_mark <= 1'b0;
    end else begin
      reversal_period_mark <= 1'b0;
      if (!reversal_en) begin
        half_count <= 32'h00000000;
        coil_polarity <= 1'b0;
      end else if (half_count == HALF_CYCLES - 1) begin
        half_count <= 32'h00000000;
        coil_polarity <= ~coil_polarity;
        reversal_period_mark <= coil_polarity;
      end else begin
        half_count <= half_count + 32'h00000001;
      end
    end
  end

  // Frequency request: software value once direct mode is taken, else analog
  wire [11:0] freq_req = analog_off ? direct_freq : cal_offset;
  wire signed [12:0] freq_s = {freq_req[11], freq_req};
  wire signed [13:0] slope_s = SLOPE[13:0];
  wire signed [26:0] freq_term = freq_s * slope_s;
  wire [23:0] off_sq = field_offset * field_offset;
  wire signed [26:0] lin_sum = freq_term + $signed({3'b000, off_sq});
  wire [25:0] sqrt_in = lin_sum[26] ? 26'h0000000 : lin_sum[25:0];

  reg [25:0] sqrt_hold;
  reg sqrt_start;
  wire sqrt_done;
  wire [12:0] sqrt_root;

  // One shared root engine; done alone paces the sequencer
  sfc_isqrt #(
    .IN_W(26),
    .OUT_W(13)
  ) u_sqrt (
    .clk(clk),
    .rst(rst),
    .start(sqrt_start),
    .operand(sqrt_hold),
    .busy(),
    .done(sqrt_done),
    .root(sqrt_root)
  );

  // Root sequencer: sample operand, run, clamp into DAC range, repeat
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_RUN;
      ST_RUN: if (sqrt_done) next_state = ST_LOAD;
      ST_LOAD: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      sqrt_hold <= 26'h0000000;
      sqrt_start <= 1'b0;
      field_dac <= `SFC_OFFSET_RESET;
    end else begin
      state <= next_state;
      sqrt_start <= (state == ST_IDLE);
      if (state == ST_IDLE)
        sqrt_hold <= sqrt_in;
      if (state == ST_LOAD) begin
        // Floor at minimum keeps the wrong Zeeman line out of reach
        if (sqrt_root < {1'b0, `SFC_DAC_MIN})
          field_dac <= `SFC_DAC_MIN;
        else if (sqrt_root > {1'b0, `SFC_DAC_MAX})
          field_dac <= `SFC_DAC_MAX;
        else
          field_dac <= sqrt_root[11:0];
      end
    end
  end

  // Read mux; unmapped addresses answer zero
  always @* begin
    next_rdata = 32'h00000000;
    case (addr)
      `SFC_ADDR_SYNTH:
        next_rdata = {1'b0, synth_a, synth_n, synth_r};
      `SFC_ADDR_SYNTH_STORED:
        next_rdata = {1'b0, stored_a, stored_n, stored_r};
      `SFC_ADDR_REVERSAL:
        next_rdata = {31'h00000000, reversal_en};
      `SFC_ADDR_OFFSET:
        next_rdata = {20'h00000, field_offset};
      `SFC_ADDR_OFFSET_STORED:
        next_rdata = {20'h00000, stored_offset};
      `SFC_ADDR_DAC:
        next_rdata = {20'h00000, field_dac};
      `SFC_ADDR_FREQ:
        next_rdata = {{20{freq_req[11]}}, freq_req};
      `SFC_ADDR_STATUS:
        next_rdata = {29'h00000000, coil_polarity, analog_off, reject};
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rst)
      rdata <= 32'h00000000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 32'h00000000;
  end
endmodule // sfc_control

//--- verification/sfc_control_asserts.sv
// Purpose: Port-level checks on sfc_control
// Assumes: Half period of 8 cycles in simulation
// Notes: Bound to every sfc_control below
`timescale 1ns/10ps
module sfc_chk #(
  parameter integer HALF_CYCLES = 8
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire [12:0] synth_r,
  input wire [11:0] synth_n,
  input wire [5:0] synth_a,
  input wire synth_load,
  input wire [11:0] field_dac,
  input wire coil_polarity,
  input wire reversal_period_mark
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // Repetition needs a literal, so the half period is fixed at 8 here
  sequence s_half;
    coil_polarity[*8] ##1 !coil_polarity;
  endsequence
  property p_dac_range;
    field_dac >= 12'h3E8;
  endproperty
  property p_synth_apply;
    wr && addr == 8'h00 && !wdata[31] && wdata[12:0] >= 13'h05DC && wdata[24:13] >= 12'h320
      |=> synth_load && {synth_a, synth_n, synth_r} == $past(wdata[30:0]);
  endproperty
  property p_synth_reject;
    wr && addr == 8'h00 && wdata[12:0] < 13'h05DC |=> !synth_load && $stable(synth_r);
  endproperty
  property p_load_cause;
    $changed({synth_r, synth_n, synth_a}) |-> synth_load;
  endproperty
  property p_read_idle;
    !rd |=> rdata == 32'h0;
  endproperty
  property p_read_synth;
    rd && addr == 8'h00 |=> rdata == {1'b0, $past({synth_a, synth_n, synth_r})};
  endproperty
  property p_pol_half;
    $rose(coil_polarity) |-> s_half;
  endproperty
  property p_period_mark;
    $rose(coil_polarity) |-> s_half ##0 reversal_period_mark;
  endproperty
  property p_rev_off;
    wr && addr == 8'h0C && wdata == 32'h0 |-> ##2 !coil_polarity [*8];
  endproperty
  a_dac_range: assert property (p_dac_range) else $error("dac low");
  a_synth_apply: assert property (p_synth_apply) else $error("synth not applied");
  a_synth_reject: assert property (p_synth_reject) else $error("synth not refused");
  a_load_cause: assert property (p_load_cause) else $error("synth moved silently");
  a_read_idle: assert property (p_read_idle) else $error("rdata not idle");
  a_read_synth: assert property (p_read_synth) else $error("synth read wrong");
  a_pol_half: assert property (p_pol_half) else $error("half period wrong");
  a_period_mark: assert property (p_period_mark) else $error("period mark missing");
  a_rev_off: assert property (p_rev_off) else $error("coil still switching");
endmodule // sfc_chk
bind sfc_control sfc_chk #(.HALF_CYCLES(HALF_CYCLES)) sfc_chk_i (.clk, .rst, .addr, .wdata,
  .wr, .rd, .rdata, .synth_r, .synth_n, .synth_a, .synth_load, .field_dac, .coil_polarity,
  .reversal_period_mark);

//--- verification/sfc_host.sv
// Purpose: Host side of the register port
// Assumes: One-cycle strobes, read data one cycle later
// Notes: Released data is inverted so stale values never pass
`timescale 1ns/10ps
module sfc_host (
  input wire clk,
  input wire [31:0] rdata,
  output reg [7:0] addr = 8'h00,
  output reg [31:0] wdata = 32'h0,
  output reg wr = 1'b0,
  output reg rd = 1'b0
);
  // Write cycle; the caller picks legal or illegal values
  task write_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
      #1;
    end
  endtask
  // Read cycle; data taken in the answer cycle
  task read_reg(input [7:0] a, output [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
endmodule // sfc_host

//--- verification/tb_top.sv
// Purpose: Self-checking bench for sfc_control
// Assumes: Half period 8 cycles, slope 1450
// Notes: Expected values worked out here
`timescale 1ns/10ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [11:0] cal_offset = 12'h000;
  wire [7:0] addr;
  wire [31:0] wdata, rdata;
  wire [12:0] synth_r;
  wire [11:0] synth_n, field_dac;
  wire [5:0] synth_a;
  wire wr, rd, synth_load, coil_polarity, reversal_period_mark;
  integer err_count = 0;
  integer comparisons = 0;
  reg [31:0] got;
  time t0;
  localparam [31:0] sp_def = {1'b0, 6'h3F, 12'h5BA, 13'h0A32};
  localparam [31:0] sp_new = {1'b0, 6'h16, 12'hBC6, 13'h14F3};
  localparam [31:0] sp_lim = {1'b0, 6'h00, 12'h320, 13'h1FFF};
  sfc_control #(.HALF_CYCLES(8)) sfc_control_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .cal_offset, .synth_r, .synth_n, .synth_a, .synth_load, .field_dac, .coil_polarity,
    .reversal_period_mark);
  sfc_host sfc_host_i (.clk, .rdata, .addr, .wdata, .wr, .rd);
  // 4 ns clock
  always #2 clk = ~clk;
  // Compare and count
  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Status bit 2 follows the coil, so only its flags are compared
  task rchk(input [7:0] a, input [31:0] e);
    begin
      sfc_host_i.read_reg(a, got);
      chk(a == 8'h20 ? got & 32'h3 : got, e);
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    sfc_host_i.write_reg(a, d);
  endtask
  // Floor root; 40 cycles cover a root pass already under way plus a fresh one
  task dchk(input integer v);
    integer r;
    begin
      r = 0;
      while ((r + 1) * (r + 1) <= v)
        r = r + 1;
      repeat (40) @(posedge clk);
      rchk(8'h18, r);
    end
  endtask
  task wait_fall;
    begin
      @(posedge coil_polarity);
      @(negedge coil_polarity);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    summarize;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h00, sp_def);
    rchk(8'h0C, 32'h1);
    rchk(8'h24, 32'h0);
    dchk(9000000);
    wreg(8'h00, sp_new);
    chk({1'b0, synth_a, synth_n, synth_r}, sp_new);
    rchk(8'h04, sp_def);
    wreg(8'h08, 32'h1);
    rchk(8'h04, sp_new);
    wreg(8'h00, {1'b0, 6'h3F, 12'h320, 13'h05DB});
    wreg(8'h00, {1'b0, 6'h00, 12'h31F, 13'h1FFF});
    rchk(8'h20, 32'h1);
    wreg(8'h00, sp_lim);
    rchk(8'h00, sp_lim);
    wreg(8'h10, 32'h08FB);
    wreg(8'h10, 32'h0E11);
    rchk(8'h10, 32'h0BB8);
    wreg(8'h10, 32'h0E10);
    wreg(8'h08, 32'h2);
    rchk(8'h14, 32'h0E10);
    wreg(8'h10, 32'h08FC);
    @(posedge clk) cal_offset <= 12'h100;
    wreg(8'h1C, 32'hFFFFF200);
    rchk(8'h1C, 32'h00000100);
    wreg(8'h1C, 32'hFFFFF830);
    rchk(8'h1C, 32'hFFFFF830);
    rchk(8'h20, 32'h3);
    dchk(5290000 - 2900000);
    wait_fall;
    t0 = $time;
    wait_fall;
    chk(($time - t0) / 4, 32'h10);
    wreg(8'h0C, 32'h0);
    rchk(8'h0C, 32'h0);
    repeat (8) @(negedge clk); // Lands in a high phase if the disable were ignored
    chk({31'h0, coil_polarity}, 32'h0);
    wreg(8'h0C, 32'h1);
    wait_fall;
    wreg(8'h0C, 32'h0);
    wreg(8'h08, 32'h4);
    rchk(8'h00, sp_new);
    rchk(8'h10, 32'h0E10);
    rchk(8'h0C, 32'h1);
    rchk(8'h20, 32'h0);
    rchk(8'h1C, 32'h00000100);
    dchk(256 * 1450 + 12960000);
    summarize;
  end
endmodule // tb_top
